// >>> slvd_pkg.sv
// constants and carrier types for the supply monitor control block
package slvd_pkg;
   localparam int                LEVEL_W         = 4;
   localparam logic [3:0]        LEVEL_EXTERNAL  = 4'hF;
   localparam logic [3:0]        LEVEL_RESET     = 4'h5;
   localparam logic              ENABLE_RESET    = 1'h0;
   localparam logic              IRQ_EN_RESET    = 1'h0;
   // reference settle time, ns; arbitrary stand-in value
   localparam int                SETTLE_NS       = 20000;
   localparam int                CLK_PERIOD_NS   = 25;
   localparam int                SETTLE_CYC      =
      (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int                CNT_W           = 16;

   typedef struct packed {
      logic                power_enable;
      logic                irq_enable;
      logic [3:0]          trip_level;
      logic                flag_clear;
   } slvd_ctrl_s;

   typedef struct packed {
      logic                supply_low_flag;
      logic                reference_stable_flag;
      logic                irq;
      logic                wake;
   } slvd_stat_s;

   typedef enum logic [1:0] {
      SLVD_OFF    = 2'b00,
      SLVD_SETTLE = 2'b01,
      SLVD_READY  = 2'b10
   } slvd_state_e;
endpackage

// >>> slvd_supply_monitor.sv
// supply monitor control logic: trip select, settle, latched low flag
//
// Contract
// - set low flag when comparator says selected tap is below reference
// - enabled and set flag requests interrupt to redirect execution
// - software fully controls detector, can switch it off and on
// - four-bit trip select chooses one of fifteen divider settings, or the external pin
// - select all ones routes external sense pin to comparator
// - power enable powers detector up; clear powers it down, stops detection
// - read-only reference stable flag shows detection is reliable
// - detector keeps working in sleep, sets flag and wakes device
// - any reset returns controls to reset state, detector off
`timescale 1ns/10ps
`default_nettype none
module slvd_supply_monitor #(
   parameter int SETTLE_CYCLES = slvd_pkg::SETTLE_CYC
) (
   input  wire logic                  clk_sys,
   input  wire logic                  rst,
   input  wire slvd_pkg::slvd_ctrl_s  ctrl,
   input  wire logic                  comparator_low,
   output logic                       analog_power_enable,
   output logic [3:0]                 divider_tap_select,
   output logic                       external_sense_input_select,
   output slvd_pkg::slvd_stat_s       status
);

   ////////////////////////////////////////////////////////////////////////
   // control registers
   logic                     en_q;
   logic                     en_d;
   logic                     ie_q;
   logic                     ie_d;
   logic [3:0]               lvl_q;
   logic [3:0]               lvl_d;

   always_comb begin
      en_d  = ctrl.power_enable;
      ie_d  = ctrl.irq_enable;
      lvl_d = ctrl.trip_level;
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         en_q  <= slvd_pkg::ENABLE_RESET;
         ie_q  <= slvd_pkg::IRQ_EN_RESET;
         lvl_q <= slvd_pkg::LEVEL_RESET;
      end else begin
         en_q  <= en_d;
         ie_q  <= ie_d;
         lvl_q <= lvl_d;
      end
   end

   // power and tap select come straight from flops; external select is decoded from lvl_q
   always_comb begin
      analog_power_enable         = en_q;
      divider_tap_select          = lvl_q;
      external_sense_input_select = lvl_q == slvd_pkg::LEVEL_EXTERNAL;
   end

   ////////////////////////////////////////////////////////////////////////
   // comparator synchroniser
   logic                     cmp_meta_q;
   logic                     cmp_sync_q;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cmp_meta_q <= 1'h0;
         cmp_sync_q <= 1'h0;
      end else begin
         cmp_meta_q <= comparator_low;
         cmp_sync_q <= cmp_meta_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // reference settle sequencing
   slvd_pkg::slvd_state_e    st_q;
   slvd_pkg::slvd_state_e    st_d;
   logic [slvd_pkg::CNT_W-1:0] cnt_q;
   logic [slvd_pkg::CNT_W-1:0] cnt_d;

   always_comb begin
      st_d  = st_q;
      cnt_d = cnt_q;
      unique case (st_q)
         slvd_pkg::SLVD_OFF: begin
            cnt_d = '0;
            if (en_q) begin
               st_d = slvd_pkg::SLVD_SETTLE;
            end
         end
         slvd_pkg::SLVD_SETTLE: begin
            cnt_d = cnt_q + 1'h1;
            if (!en_q) begin
               st_d = slvd_pkg::SLVD_OFF;
            end else if (cnt_q == slvd_pkg::CNT_W'(SETTLE_CYCLES - 1)) begin
               st_d = slvd_pkg::SLVD_READY;
            end
         end
         slvd_pkg::SLVD_READY: begin
            if (!en_q) begin
               st_d = slvd_pkg::SLVD_OFF;
            end
         end
         default: begin
            st_d = slvd_pkg::SLVD_OFF;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_q  <= slvd_pkg::SLVD_OFF;
         cnt_q <= '0;
      end else begin
         st_q  <= st_d;
         cnt_q <= cnt_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // sticky low flag; set beats a same-cycle clear
   logic                     flag_q;
   logic                     flag_d;
   logic                     trip;

   always_comb begin
      // comparator output is junk while powered down
      trip   = en_q && cmp_sync_q;
      flag_d = flag_q;
      if (ctrl.flag_clear) begin
         flag_d = 1'h0;
      end
      if (trip) begin
         flag_d = 1'h1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         flag_q <= 1'h0;
      end else begin
         flag_q <= flag_d;
      end
   end

   always_comb begin
      status.supply_low_flag       = flag_q;
      status.reference_stable_flag = (st_q == slvd_pkg::SLVD_READY);
      status.irq                   = flag_q && ie_q;
      // wake needs no clock gating here; sleep logic samples this level
      status.wake                  = flag_q;
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   sequence s_trip_seen;
      en_q && cmp_sync_q;
   endsequence

   // comparator high now, detector on two edges later
   sequence s_pin_low_on;
      comparator_low ##2 en_q;
   endsequence

   // comparator quiet two edges, flag still clear
   sequence s_pin_quiet;
      !comparator_low ##1 !comparator_low ##1 !flag_q;
   endsequence

   chk_flag_sets_trip: assert property (
      @(posedge clk_sys) disable iff (rst)
      s_trip_seen |=> flag_q)
      else $error("flag missed trip");
   chk_flag_holds_val: assert property (
      @(posedge clk_sys) disable iff (rst)
      flag_q && !ctrl.flag_clear |=> flag_q)
      else $error("flag dropped without clear");
   chk_irq_follows_flag: assert property (
      @(posedge clk_sys) disable iff (rst)
      ctrl.irq_enable |=> status.irq == status.supply_low_flag)
      else $error("irq not following flag");
   chk_irq_masked_off: assert property (
      @(posedge clk_sys) disable iff (rst)
      !ctrl.irq_enable |=> !status.irq)
      else $error("irq while masked");
   chk_ext_sense_sel: assert property (
      @(posedge clk_sys) disable iff (rst)
      ctrl.trip_level == slvd_pkg::LEVEL_EXTERNAL |=>
      external_sense_input_select)
      else $error("external not chosen");
   chk_ext_sense_off: assert property (
      @(posedge clk_sys) disable iff (rst)
      ctrl.trip_level != slvd_pkg::LEVEL_EXTERNAL |=>
      !external_sense_input_select)
      else $error("external chosen for a tap");
   chk_tap_follow_sel: assert property (
      @(posedge clk_sys) disable iff (rst)
      1'h1 |=> divider_tap_select == $past(ctrl.trip_level))
      else $error("tap select stale");
   chk_off_not_stable: assert property (
      @(posedge clk_sys) disable iff (rst)
      !en_q |=> !status.reference_stable_flag)
      else $error("stable while off");
   chk_power_follow_en: assert property (
      @(posedge clk_sys) disable iff (rst)
      !ctrl.power_enable |=> !analog_power_enable)
      else $error("power not dropped");
   chk_reset_off_state: assert property (
      @(posedge clk_sys)
      rst |=> !analog_power_enable && !status.supply_low_flag &&
              !status.reference_stable_flag &&
              divider_tap_select == slvd_pkg::LEVEL_RESET)
      else $error("reset left detector on");
   // a single-flop path would let the flag react one edge early
   chk_sync_two_stage: assert property (
      @(posedge clk_sys) disable iff (rst)
      s_pin_quiet |=> (!flag_q) [*2])
      else $error("flag reacted before sync");
   chk_flag_three_edges: assert property (
      @(posedge clk_sys) disable iff (rst)
      s_pin_low_on |=> flag_q)
      else $error("flag late after comparator");
   chk_wake_on_flag: assert property (
      @(posedge clk_sys) disable iff (rst)
      s_trip_seen |=> status.wake)
      else $error("no wake");
   chk_off_no_trip: assert property (
      @(posedge clk_sys) disable iff (rst)
      !en_q && !flag_q |=> !flag_q)
      else $error("flag set while off");
endmodule
`default_nettype wire

// >>> tb_slvd_supply_monitor.sv
// self-checking bench for the supply monitor control block
`timescale 1ns/10ps
`default_nettype none
module tb_slvd_supply_monitor;
   localparam int SETTLE = 4;
   logic                 clk_sys;
   logic                 rst;
   slvd_pkg::slvd_ctrl_s ctrl;
   logic                 comparator_low;
   logic                 analog_power_enable;
   logic [3:0]           divider_tap_select;
   logic                 external_sense_input_select;
   slvd_pkg::slvd_stat_s status;
   int                   num_errors;
   int                   n_checks;
   int                   cycles;

   slvd_supply_monitor #(.SETTLE_CYCLES(SETTLE)) slvd_supply_monitor_i (
      .clk_sys                     (clk_sys),
      .rst                         (rst),
      .ctrl                        (ctrl),
      .comparator_low              (comparator_low),
      .analog_power_enable         (analog_power_enable),
      .divider_tap_select          (divider_tap_select),
      .external_sense_input_select (external_sense_input_select),
      .status                      (status)
   );

   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic tick(input int n);
      repeat (n) @(negedge clk_sys);
   endtask

   task automatic check_bit(input logic got, input logic exp, input string s);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: %s", $time, s);
      end
   endtask

   task automatic check_nib(input logic [3:0] got, input logic [3:0] exp,
                            input string s);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: %s", $time, s);
      end
   endtask

   // only valid while rst is high; tap follows ctrl once released
   task automatic check_quiet;
      check_bit(analog_power_enable, 1'h0, "power on in reset");
      check_nib(divider_tap_select, slvd_pkg::LEVEL_RESET, "tap");
      check_bit(status.supply_low_flag, 1'h0, "flag in reset");
      check_bit(status.reference_stable_flag, 1'h0, "stable");
      check_bit(status.irq, 1'h0, "irq in reset");
   endtask

   task automatic finish_test;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // whole run is under seventy cycles
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 2000) begin
         num_errors++;
         finish_test();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   initial begin
      rst = 1'h1;
      ctrl = '0;
      comparator_low = 1'h0;
      num_errors = 0;
      n_checks = 0;
      cycles = 0;
      tick(12);
      check_quiet();
      rst = 1'h0;
      for (int i = 0; i < 16; i++) begin
         ctrl.trip_level = 4'(i);
         tick(1);
         check_nib(divider_tap_select, 4'(i), "tap");
         check_bit(external_sense_input_select, &4'(i), "ext");
      end
      ctrl.power_enable = 1'h1;
      tick(1);
      check_bit(analog_power_enable, 1'h1, "power up");
      check_bit(status.reference_stable_flag, 1'h0, "early stable");
      tick(SETTLE + 2);
      check_bit(status.reference_stable_flag, 1'h1, "not stable");
      comparator_low = 1'h1;
      tick(2);
      check_bit(status.supply_low_flag, 1'h0, "flag unsynced");
      tick(1);
      check_bit(status.supply_low_flag, 1'h1, "flag not set");
      check_bit(status.wake, 1'h1, "no wake");
      check_bit(status.irq, 1'h0, "irq masked");
      ctrl.irq_enable = 1'h1;
      comparator_low = 1'h0;
      tick(1);
      check_bit(status.irq, 1'h1, "irq missing");
      tick(4);
      check_bit(status.supply_low_flag, 1'h1, "flag lost");
      // clear against a standing trip: set must win
      comparator_low = 1'h1;
      tick(3);
      ctrl.flag_clear = 1'h1;
      tick(1);
      check_bit(status.supply_low_flag, 1'h1, "clear beat set");
      comparator_low = 1'h0;
      tick(3);
      check_bit(status.supply_low_flag, 1'h0, "clear failed");
      check_bit(status.irq, 1'h0, "irq stuck");
      check_bit(status.wake, 1'h0, "wake stuck");
      ctrl.flag_clear = 1'h0;
      ctrl.power_enable = 1'h0;
      comparator_low = 1'h1;
      tick(1);
      check_bit(analog_power_enable, 1'h0, "power down");
      tick(1);
      check_bit(status.reference_stable_flag, 1'h0, "stable off");
      tick(4);
      check_bit(status.supply_low_flag, 1'h0, "trip while off");
      ctrl.power_enable = 1'h1;
      ctrl.trip_level = 4'hF;
      tick(SETTLE + 4);
      check_bit(status.supply_low_flag, 1'h1, "ext trip");
      check_bit(status.irq, 1'h1, "irq ext");
      ctrl.irq_enable = 1'h0;
      tick(1);
      check_bit(status.irq, 1'h0, "irq unmasked");
      check_bit(status.supply_low_flag, 1'h1, "flag lost");
      comparator_low = 1'h0;
      rst = 1'h1;
      tick(2);
      check_quiet();
      finish_test();
   end
endmodule
`default_nettype wire
